//--- verilog/wwd_regs.svh
/*
 Register map, field positions, reset values, feed keys and counting constants of the windowed watchdog.
 Assumes a 6-bit byte address on the register bus and a word-aligned map.
*/
`ifndef WWD_REGS_SVH
`define WWD_REGS_SVH
// ============================================================
// Offsets
`define WWD_OFS_MODE      6'h00
`define WWD_OFS_TIMEOUT   6'h04
`define WWD_OFS_FEED      6'h08
`define WWD_OFS_COUNT     6'h0C
`define WWD_OFS_WINDOW    6'h10
`define WWD_OFS_WARN      6'h14
`define WWD_OFS_IRQ_STAT  6'h18
`define WWD_OFS_IRQ_CLR   6'h1C
`define WWD_OFS_IRQ_EN    6'h20
`define WWD_OFS_RST_CAUSE 6'h24
// ============================================================
// Fields
`define WWD_MODE_EN       0
`define WWD_MODE_RSTMODE  1
`define WWD_MODE_WIN      2
`define WWD_MODE_WARN     3
`define WWD_MODE_W        4
`define WWD_IRQ_TIMEOUT   0
`define WWD_IRQ_WINDOW    1
`define WWD_IRQ_FEED      2
`define WWD_IRQ_WARN      3
`define WWD_IRQ_W         4
// ============================================================
// Values
`define WWD_FEED_KEY1     8'hAA
`define WWD_FEED_KEY2     8'h55
`define WWD_TC_MIN        24'h0000FF
`define WWD_TC_RST        24'hFFFFFF
`define WWD_WIN_RST       24'hFFFFFF
`define WWD_WARN_RST      24'h0003FF
`define WWD_PRESCALE      3'h4
`endif

//--- verilog/wwd_pkg.sv
/*
 Types shared by the windowed watchdog modules.
 Assumes nothing of its surroundings.
*/
package wwd_pkg;
	// ============================================================
	// Types
	typedef logic [23:0] wwd_count_t;
	typedef enum logic [0:0] {
		WWD_FEED_IDLE  = 1'b0,
		WWD_FEED_ARMED = 1'b1
	} wwd_feed_e;
endpackage

//--- verilog/wwd_tick.sv
/*
 Watchdog oscillator sampler and fixed prescaler producing one-cycle ticks.
 Assumes the oscillator is asynchronous to the core clock and well below half its rate.
*/
`timescale 1ns/1ns
`default_nettype none
`include "wwd_regs.svh"
module wwd_tick #(
	parameter logic [2:0] PRESCALE = `WWD_PRESCALE
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic osc_i,
	output logic      tick_o
);
	// ============================================================
	// Sampler
	logic       s1_q;
	logic       s2_q;
	logic       s3_q;
	logic       lvl_q;
	logic [2:0] div_q;
	wire        agree = (s2_q == s3_q);
	wire        osc_rise = agree & s3_q & ~lvl_q;
	wire        last = (div_q == PRESCALE - 3'h1);
	always_ff @(posedge clk_i) begin
		s1_q <= osc_i;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lvl_q <= 1'b0;
			div_q <= 3'h0;
		end else begin
			if (agree)
				lvl_q <= s3_q;
			if (osc_rise)
				div_q <= last ? 3'h0 : div_q + 3'h1;
		end
	end
	assign tick_o = osc_rise & last;
	// ============================================================
	// Checks
	property p_tick_div;
		@(posedge clk_i) disable iff (rst_i) tick_o |=> (div_q == 3'h0) && !tick_o;
	endproperty
	a_tick_div: assert property (p_tick_div) else $error("tick not followed by prescaler restart");
endmodule
`default_nettype wire

//--- verilog/wwd_count.sv
/*
 Down-counter of the watchdog with reload and expiry detection.
 Assumes tick_i is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module wwd_count #(
	parameter int W = 24
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         tick_i,
	input  wire logic         run_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] load_val_i,
	output logic      [W-1:0] count_o,
	output logic              expire_o
);
	// ============================================================
	// Counter
	logic [W-1:0] cnt_q;
	wire          is_zero = (cnt_q == '0);
	wire          step = run_i & tick_i & ~load_i;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			cnt_q <= '1;
		else if (load_i)
			cnt_q <= load_val_i;
		else if (step & ~is_zero)
			cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
	end
	assign count_o = cnt_q;
	assign expire_o = step & is_zero;
	// ============================================================
	// Checks
	property p_down;
		@(posedge clk_i) disable iff (rst_i) (step & ~is_zero) |=> (cnt_q == $past(cnt_q) - {{(W-1){1'b0}}, 1'b1});
	endproperty
	a_down: assert property (p_down) else $error("counter did not step down by one");
	property p_hold;
		@(posedge clk_i) disable iff (rst_i) (!load_i && !step) |=> $stable(cnt_q);
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved without tick or load");
endmodule
`default_nettype wire

//--- verilog/wwd_top.sv
/*
 Windowed watchdog: Avalon-MM register slave, feed sequence checker, window and warning logic,
 fault response and interrupt status.
 Assumes an Avalon master on CORE_CLK_I and a free-running watchdog oscillator on a pin.
*/
// Our own choices: the address map and register access over Avalon-MM.
// How it works
// - Counter reaching zero while enabled without reload pulses chip reset output in reset response mode, else raises time-out interrupt status.
// - With window on, reload while count above window value is a violation.
// - With warning on, count reaching warning value raises warning interrupt status.
// - Enable is set-only; cleared only by hardware reset or watchdog fault.
// - Wrong feed sequence while enabled gives reset or interrupt per response mode.
// - Reset-cause flag set on watchdog reset, survives it, cleared by software.
// - Twenty-four bit down-counter stepped by ticks from a fixed prescaler.
// - Time-out value clamps to at least 255, giving 256 to 2^24 ticks.
// - Ticks derive from the watchdog oscillator pin, not the core clock.
`timescale 1ns/1ns
`default_nettype none
`include "wwd_regs.svh"
module wwd_top #(
	parameter logic [2:0] PRESCALE = `WWD_PRESCALE
) (
	input  wire logic        CORE_CLK_I,
	input  wire logic        RST_I,
	input  wire logic        WATCHDOG_OSCILLATOR_I,
	input  wire logic [5:0]  AVS_ADDRESS_I,
	input  wire logic        AVS_READ_I,
	input  wire logic        AVS_WRITE_I,
	input  wire logic [31:0] AVS_WRITEDATA_I,
	input  wire logic [3:0]  AVS_BYTEENABLE_I,
	output logic      [31:0] AVS_READDATA_O,
	output logic             AVS_WAITREQUEST_O,
	output logic             IRQ_O,
	output logic             CHIP_RESET_O
);
	// ============================================================
	// Helpers
	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction

	// ============================================================
	// State
	logic                        served_q;
	logic [31:0]                 rdata_q;
	logic                        en_q;
	logic                        rstmode_q;
	logic                        win_en_q;
	logic                        warn_en_q;
	wwd_pkg::wwd_count_t         timeout_q;
	wwd_pkg::wwd_count_t         window_q;
	wwd_pkg::wwd_count_t         warn_q;
	logic [`WWD_IRQ_W-1:0]       stat_q;
	logic [`WWD_IRQ_W-1:0]       ie_q;
	logic                        rst_flag_q;
	logic                        chip_rst_q;
	wwd_pkg::wwd_feed_e          feed_q;
	wwd_pkg::wwd_count_t         count;
	logic                        expire;
	logic                        tick;

	// ============================================================
	// Bus decode
	// One wait cycle per access; read data is captured in the wait cycle.
	wire        req = AVS_READ_I | AVS_WRITE_I;
	wire        acc_wr = AVS_WRITE_I & served_q;
	wire        acc = req & served_q;
	wire [5:0]  a = AVS_ADDRESS_I;
	wire [31:0] wd = AVS_WRITEDATA_I;
	wire [3:0]  be = AVS_BYTEENABLE_I;
	wire        wr_mode = acc_wr & (a == `WWD_OFS_MODE) & be[0];
	wire        wr_tc = acc_wr & (a == `WWD_OFS_TIMEOUT);
	wire        wr_feed = acc_wr & (a == `WWD_OFS_FEED) & be[0];
	wire        wr_win = acc_wr & (a == `WWD_OFS_WINDOW);
	wire        wr_warn = acc_wr & (a == `WWD_OFS_WARN);
	wire        wr_clr = acc_wr & (a == `WWD_OFS_IRQ_CLR) & be[0];
	wire        wr_ie = acc_wr & (a == `WWD_OFS_IRQ_EN) & be[0];
	wire        wr_cause = acc_wr & (a == `WWD_OFS_RST_CAUSE) & be[0];
	assign AVS_WAITREQUEST_O = req & ~served_q;

	// ============================================================
	// Feed sequence
	wire key1 = wr_feed & (wd[7:0] == `WWD_FEED_KEY1);
	wire key2 = wr_feed & (wd[7:0] == `WWD_FEED_KEY2);
	wire armed = (feed_q == wwd_pkg::WWD_FEED_ARMED);
	wire feed_ok = armed & key2;
	// Any access while armed other than the second key breaks the sequence
	wire bad_feed = acc & ~feed_ok & (armed | (wr_feed & ~key1));
	wire feed_go = ~armed & key1;

	// ============================================================
	// Events
	wire en_set = wr_mode & wd[`WWD_MODE_EN] & ~en_q;
	wire load = feed_ok | en_set;
	wire to_evt = en_q & expire;
	wire win_evt = en_q & win_en_q & feed_ok & (count > window_q);
	wire bad_evt = en_q & bad_feed;
	wire warn_evt = en_q & warn_en_q & tick & (count == warn_q) & ~load;
	wire fault = to_evt | win_evt | bad_evt;
	wire wd_reset = fault & rstmode_q;
	wire [`WWD_IRQ_W-1:0] evts = {warn_evt, bad_evt, win_evt, to_evt};
	wire [`WWD_IRQ_W-1:0] clr_bits = wr_clr ? wd[`WWD_IRQ_W-1:0] : '0;
	wire [31:0] tc_m = be_merge({8'h00, timeout_q}, wd, be);
	wire [31:0] win_m = be_merge({8'h00, window_q}, wd, be);
	wire [31:0] warn_m = be_merge({8'h00, warn_q}, wd, be);
	// Short values would give a time-out below the documented floor
	wire [23:0] tc_new = (tc_m[23:0] < `WWD_TC_MIN) ? `WWD_TC_MIN : tc_m[23:0];

	// ============================================================
	// Read mux
	wire [31:0] rd_mux =
		(a == `WWD_OFS_MODE)      ? {28'h0000000, warn_en_q, win_en_q, rstmode_q, en_q} :
		(a == `WWD_OFS_TIMEOUT)   ? {8'h00, timeout_q} :
		(a == `WWD_OFS_COUNT)     ? {8'h00, count} :
		(a == `WWD_OFS_WINDOW)    ? {8'h00, window_q} :
		(a == `WWD_OFS_WARN)      ? {8'h00, warn_q} :
		(a == `WWD_OFS_IRQ_STAT)  ? {28'h0000000, stat_q} :
		(a == `WWD_OFS_IRQ_EN)    ? {28'h0000000, ie_q} :
		(a == `WWD_OFS_RST_CAUSE) ? {31'h00000000, rst_flag_q} : 32'h00000000;

	// ============================================================
	// Bus registers
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			served_q <= 1'b0;
			rdata_q  <= 32'h00000000;
		end else begin
			served_q <= req & ~served_q;
			if (AVS_READ_I & ~served_q)
				rdata_q <= rd_mux;
		end
	end
	assign AVS_READDATA_O = rdata_q;

	// ============================================================
	// Mode and feed state
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			en_q      <= 1'b0;
			rstmode_q <= 1'b0;
			win_en_q  <= 1'b0;
			warn_en_q <= 1'b0;
			feed_q    <= wwd_pkg::WWD_FEED_IDLE;
		end else if (fault) begin
			en_q      <= 1'b0;
			feed_q    <= wwd_pkg::WWD_FEED_IDLE;
			if (rstmode_q) begin
				rstmode_q <= 1'b0;
				win_en_q  <= 1'b0;
				warn_en_q <= 1'b0;
			end
		end else begin
			if (en_set)
				en_q <= 1'b1;
			if (wr_mode) begin
				rstmode_q <= rstmode_q | wd[`WWD_MODE_RSTMODE];
				win_en_q  <= wd[`WWD_MODE_WIN];
				warn_en_q <= wd[`WWD_MODE_WARN];
			end
			if (feed_ok | bad_feed)
				feed_q <= wwd_pkg::WWD_FEED_IDLE;
			else if (feed_go)
				feed_q <= wwd_pkg::WWD_FEED_ARMED;
		end
	end

	// ============================================================
	// Value registers
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			timeout_q <= `WWD_TC_RST;
			window_q  <= `WWD_WIN_RST;
			warn_q    <= `WWD_WARN_RST;
			ie_q      <= '0;
		end else begin
			if (wr_tc)
				timeout_q <= tc_new;
			if (wr_win)
				window_q <= win_m[23:0];
			if (wr_warn)
				warn_q <= warn_m[23:0];
			if (wr_ie)
				ie_q <= wd[`WWD_IRQ_W-1:0];
		end
	end

	// ============================================================
	// Status, cause flag and reset pulse
	// Set wins over clear so no event is lost
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			stat_q     <= '0;
			rst_flag_q <= 1'b0;
			chip_rst_q <= 1'b0;
		end else begin
			stat_q     <= (stat_q & ~clr_bits) | evts;
			rst_flag_q <= wd_reset | (rst_flag_q & ~(wr_cause & wd[0]));
			chip_rst_q <= wd_reset;
		end
	end
	assign IRQ_O = |(stat_q & ie_q);
	assign CHIP_RESET_O = chip_rst_q;

	// ============================================================
	// Tick source and counter
	wwd_tick #(
		.PRESCALE (PRESCALE)
	) u_tick (
		.clk_i  (CORE_CLK_I),
		.rst_i  (RST_I),
		.osc_i  (WATCHDOG_OSCILLATOR_I),
		.tick_o (tick)
	);
	wwd_count #(
		.W (24)
	) u_count (
		.clk_i      (CORE_CLK_I),
		.rst_i      (RST_I),
		.tick_i     (tick),
		.run_i      (en_q),
		.load_i     (load),
		.load_val_i (timeout_q),
		.count_o    (count),
		.expire_o   (expire)
	);

	// ============================================================
	// Checks
	property p_timeout_rst;
		@(posedge CORE_CLK_I) disable iff (RST_I) (to_evt && rstmode_q) |=> CHIP_RESET_O ##1 !CHIP_RESET_O;
	endproperty
	a_timeout_rst: assert property (p_timeout_rst) else $error("expiry did not give one reset pulse");
	property p_window;
		@(posedge CORE_CLK_I) disable iff (RST_I) win_evt |=> stat_q[`WWD_IRQ_WINDOW] && !en_q;
	endproperty
	a_window: assert property (p_window) else $error("early reload not flagged");
	property p_warn;
		@(posedge CORE_CLK_I) disable iff (RST_I) warn_evt |=> stat_q[`WWD_IRQ_WARN];
	endproperty
	a_warn: assert property (p_warn) else $error("warning not raised");
	property p_no_disable;
		@(posedge CORE_CLK_I) disable iff (RST_I) (en_q && !fault) |=> en_q;
	endproperty
	a_no_disable: assert property (p_no_disable) else $error("watchdog disabled without fault");
	property p_bad_feed;
		@(posedge CORE_CLK_I) disable iff (RST_I) (bad_evt && !rstmode_q) |=> stat_q[`WWD_IRQ_FEED] && !CHIP_RESET_O;
	endproperty
	a_bad_feed: assert property (p_bad_feed) else $error("bad feed not reported as interrupt");
	property p_flag;
		@(posedge CORE_CLK_I) disable iff (RST_I) $rose(CHIP_RESET_O) |-> rst_flag_q ##1 rst_flag_q;
	endproperty
	a_flag: assert property (p_flag) else $error("reset cause flag missing");
	property p_min_tc;
		@(posedge CORE_CLK_I) disable iff (RST_I) wr_tc |=> (timeout_q >= `WWD_TC_MIN);
	endproperty
	a_min_tc: assert property (p_min_tc) else $error("time-out below floor");
	property p_feed_reload;
		@(posedge CORE_CLK_I) disable iff (RST_I) feed_ok |=> (count == $past(timeout_q));
	endproperty
	a_feed_reload: assert property (p_feed_reload) else $error("feed did not reload counter");
	property p_wait_one;
		@(posedge CORE_CLK_I) disable iff (RST_I) $rose(req) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("bus answer not after one wait cycle");
	// Status bits only fall through a clear write
	property p_sticky;
		@(posedge CORE_CLK_I) disable iff (RST_I)
			!wr_clr |=> ((stat_q & $past(stat_q)) == $past(stat_q));
	endproperty
	a_sticky: assert property (p_sticky) else $error("status bit lost without clear");
	property p_expire;
		@(posedge CORE_CLK_I) disable iff (RST_I)
			(en_q && tick && (count == '0) && !load) |=> stat_q[`WWD_IRQ_TIMEOUT] && !en_q;
	endproperty
	a_expire: assert property (p_expire) else $error("expiry not flagged");
	property p_chip_pulse;
		@(posedge CORE_CLK_I) disable iff (RST_I) CHIP_RESET_O |=> !CHIP_RESET_O;
	endproperty
	a_chip_pulse: assert property (p_chip_pulse) else $error("reset request longer than one cycle");
	property p_in_window;
		@(posedge CORE_CLK_I) disable iff (RST_I)
			(en_q && feed_ok && (!win_en_q || count <= window_q) && !to_evt) |=> en_q;
	endproperty
	a_in_window: assert property (p_in_window) else $error("feed inside window stopped watchdog");
	property p_intervene;
		@(posedge CORE_CLK_I) disable iff (RST_I)
			(en_q && armed && acc && !key2) |=> stat_q[`WWD_IRQ_FEED] && !en_q;
	endproperty
	a_intervene: assert property (p_intervene) else $error("broken key pair not flagged");
	property p_enable_load;
		@(posedge CORE_CLK_I) disable iff (RST_I) en_set |=> en_q && (count == $past(timeout_q));
	endproperty
	a_enable_load: assert property (p_enable_load) else $error("enable did not load time-out");
	property p_flag_hold;
		@(posedge CORE_CLK_I) disable iff (RST_I) (rst_flag_q && !(wr_cause && wd[0])) |=> rst_flag_q;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("reset cause flag lost");
endmodule
`default_nettype wire

//--- verilog/wwd_dummy_guard.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

//--- verif/tb.sv
/*
 Self-checking bench for the windowed watchdog top: register bus tasks, then scenarios in sequence.
 Assumes one core clock, a bench-made oscillator pin and the assertions inside the design files.
*/
`timescale 1ns/1ns
`default_nettype none
`include "wwd_regs.svh"
module tb;
	// ============================================================
	// Signals
	logic        clk, rst, osc, osc_run, rd, wr, irq, chip_rst, wait_req, cr_q;
	logic [5:0]  adr;
	logic [31:0] wd, rdata, q;
	logic [3:0]  be;
	int          n_errors, total_checks, cyc, c0, osc_div, pulses, rst_hi;

	wwd_top #(.PRESCALE(3'h4)) wwd_top_inst (
		.CORE_CLK_I(clk), .RST_I(rst), .WATCHDOG_OSCILLATOR_I(osc),
		.AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
		.AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
		.AVS_WAITREQUEST_O(wait_req), .IRQ_O(irq), .CHIP_RESET_O(chip_rst));

	// ============================================================
	// Clock, oscillator of 8 core cycles, reset pulse monitor
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		cr_q <= chip_rst;
		if (chip_rst === 1'b1) rst_hi <= rst_hi + 1;
		if (chip_rst === 1'b1 && cr_q !== 1'b1) pulses <= pulses + 1;
		if (osc_run) begin
			osc_div <= (osc_div == 3) ? 0 : osc_div + 1;
			if (osc_div == 3) osc <= ~osc;
		end
	end

	// ============================================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic hang(input string nm);
		n_errors++;
		$display("MISMATCH %s expected done seen timeout", nm);
		results;
	endtask
	// One idle edge first, so a release and the next request never share a time step
	task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= ~w;
		be <= 4'hF;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wait_req !== 1'b0 && n < 16);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 16) hang("bus");
	endtask
	task automatic w(input logic [5:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask
	task automatic rc(input string nm, input logic [5:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		chk(nm, q, exp);
	endtask
	task automatic wait_irq(input int lim);
		int t;
		for (t = 0; irq !== 1'b1 && t < lim; t++) @(posedge clk);
		if (irq !== 1'b1) hang("irq");
	endtask
	// Polls until the count is inside the window, never between two keys
	task automatic wait_low;
		int t;
		for (t = 0; t < 2000; t++) begin
			acc(1'b0, `WWD_OFS_COUNT, 32'h0);
			if (q <= 32'h7F) break;
		end
		if (q > 32'h7F) hang("count");
	endtask
	task automatic feed;
		w(`WWD_OFS_FEED, 32'hAA);
		w(`WWD_OFS_FEED, 32'h55);
	endtask

	// ============================================================
	// Sequence
	initial begin
		{rst, osc_run} = 2'b11;
		{rd, wr, osc, cr_q} = 4'h0;
		{adr, wd, be} = '0;
		{n_errors, total_checks, cyc, osc_div, pulses, rst_hi} = '0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rc("mode", `WWD_OFS_MODE, 32'h0);
		rc("timeout", `WWD_OFS_TIMEOUT, 32'hFFFFFF);
		rc("window", `WWD_OFS_WINDOW, 32'hFFFFFF);
		rc("warn", `WWD_OFS_WARN, 32'h3FF);
		rc("irq_en", `WWD_OFS_IRQ_EN, 32'h0);
		rc("cause", `WWD_OFS_RST_CAUSE, 32'h0);
		rc("unmapped", 6'h28, 32'h0);
		rc("misaligned", 6'h05, 32'h0);
		w(`WWD_OFS_TIMEOUT, 32'h10);
		rc("clamp", `WWD_OFS_TIMEOUT, 32'hFF);
		w(`WWD_OFS_FEED, 32'h12);
		rc("idle_feed", `WWD_OFS_IRQ_STAT, 32'h0);
		$display("test reset and limits done");
		// Warning then time-out, interrupt response; stopped oscillator freezes the count
		osc_run <= 1'b0;
		w(`WWD_OFS_WARN, 32'h80);
		w(`WWD_OFS_IRQ_EN, 32'h8);
		w(`WWD_OFS_MODE, 32'h9);
		repeat (600) @(posedge clk);
		rc("frozen", `WWD_OFS_COUNT, 32'hFF);
		w(`WWD_OFS_MODE, 32'h8);
		rc("no_disable", `WWD_OFS_MODE, 32'h9);
		osc_run <= 1'b1;
		c0 = cyc;
		wait_irq(6000);
		chk("warn_time", 32'(cyc - c0 >= 4020 && cyc - c0 <= 4115), 32'h1);
		rc("warn_stat", `WWD_OFS_IRQ_STAT, 32'h8);
		w(`WWD_OFS_IRQ_EN, 32'h1);
		@(posedge clk);
		wait_irq(6000);
		chk("tmo_time", 32'(cyc - c0 >= 8150 && cyc - c0 <= 8210), 32'h1);
		rc("tmo_stat", `WWD_OFS_IRQ_STAT, 32'h9);
		rc("tmo_off", `WWD_OFS_MODE, 32'h8);
		chk("no_reset", pulses, 32'h0);
		w(`WWD_OFS_IRQ_EN, 32'h0);
		@(posedge clk);
		chk("masked", irq, 1'b0);
		w(`WWD_OFS_IRQ_CLR, 32'h1);
		rc("clr", `WWD_OFS_IRQ_STAT, 32'h8);
		w(`WWD_OFS_IRQ_CLR, 32'h8);
		$display("test warning and time-out done");
		// Good feed, then a key pair broken by another access
		w(`WWD_OFS_IRQ_EN, 32'hF);
		w(`WWD_OFS_MODE, 32'h1);
		wait_low;
		feed;
		acc(1'b0, `WWD_OFS_COUNT, 32'h0);
		chk("reload", 32'(q >= 32'hFE && q <= 32'hFF), 32'h1);
		rc("feed_ok", `WWD_OFS_IRQ_STAT, 32'h0);
		w(`WWD_OFS_FEED, 32'hAA);
		acc(1'b0, `WWD_OFS_MODE, 32'h0);
		rc("bad_feed", `WWD_OFS_IRQ_STAT, 32'h4);
		rc("bad_off", `WWD_OFS_MODE, 32'h0);
		chk("irq", irq, 1'b1);
		w(`WWD_OFS_IRQ_CLR, 32'hF);
		// Early feed outside the window, then a feed inside it
		w(`WWD_OFS_WINDOW, 32'h80);
		w(`WWD_OFS_MODE, 32'h5);
		feed;
		rc("early", `WWD_OFS_IRQ_STAT, 32'h2);
		w(`WWD_OFS_IRQ_CLR, 32'h2);
		w(`WWD_OFS_MODE, 32'h5);
		wait_low;
		feed;
		rc("in_win", `WWD_OFS_IRQ_STAT, 32'h0);
		$display("test feed and window done");
		// Reset response: bad feed, then time-out
		w(`WWD_OFS_MODE, 32'h2);
		w(`WWD_OFS_FEED, 32'h12);
		repeat (2) @(posedge clk);
		chk("rst_pulse", pulses, 32'h1);
		rc("cause", `WWD_OFS_RST_CAUSE, 32'h1);
		w(`WWD_OFS_RST_CAUSE, 32'h1);
		rc("cause_clr", `WWD_OFS_RST_CAUSE, 32'h0);
		w(`WWD_OFS_IRQ_CLR, 32'hF);
		w(`WWD_OFS_MODE, 32'h3);
		for (int t = 0; pulses < 2 && t < 9000; t++) @(posedge clk);
		chk("tmo_rst", pulses, 32'h2);
		chk("one_cycle", rst_hi, 32'h2);
		rc("tmo_cause", `WWD_OFS_RST_CAUSE, 32'h1);
		// Hardware reset is the other way out of the enabled state
		w(`WWD_OFS_MODE, 32'h1);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rc("hw_off", `WWD_OFS_MODE, 32'h0);
		rc("hw_cause", `WWD_OFS_RST_CAUSE, 32'h0);
		$display("test reset response done");
		results;
	end
endmodule
`default_nettype wire
